//--- hw/i2m_map.vh
`ifndef I2M_MAP_VH
`define I2M_MAP_VH
// Port mode code that selects two-wire master operation
`define I2M_MODE_MASTER   4'h8
`define I2M_MODE_W        4
// General call address byte, address bits and direction bit all zero
`define I2M_GENCALL_BYTE  8'h00
// Clock divider reload field width
`define I2M_DIV_W         7
// Instruction cycle has four clock phases
`define I2M_PHASE_CNT     2'h3
`define I2M_PHASE_TWO     2'h1
`define I2M_PHASE_FOUR    2'h3
// Last data bit and acknowledge bit of the bit counter
`define I2M_BITS_LAST     4'h7
`define I2M_BIT_ACK       4'h8
// Ten-bit address header pattern, upper five bits of first byte
`define I2M_TENBIT_HDR    5'h1E
`endif

//--- hw/i2m_phase_gen.v
`timescale 1ns/1ps
// Instruction-cycle phase generator, one-cycle enable on phase two and four
module i2m_phase_gen (
  // Clock and reset
  input  wire clk_sys_i,
  input  wire nrst_i,
  // Divider tick
  output reg  tick_o
);
`include "i2m_map.vh"
  reg [1:0] phase;
  // Phase counter and tick pulse
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase  <= 2'h0;
      tick_o <= 1'b0;
    end else begin
      phase  <= phase + 2'h1;
      tick_o <= (phase == `I2M_PHASE_TWO) || (phase == `I2M_PHASE_FOUR);
    end
  end
endmodule // i2m_phase_gen

//--- hw/i2m_divider.v
`timescale 1ns/1ps
// Reload-and-count-down divider, stops at zero until reloaded
module i2m_divider #(
  parameter W = 7
) (
  // Clock and reset
  input  wire         clk_sys_i,
  input  wire         nrst_i,
  // Control
  input  wire         tick_i,
  input  wire         load_i,
  input  wire         run_i,
  input  wire [W-1:0] reload_i,
  // Status
  output wire         done_o
);
  reg [W-1:0] count;
  reg         active;
  // Count down on ticks while running
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count  <= {W{1'b0}};
      active <= 1'b0;
    end else if (load_i) begin
      count  <= reload_i;
      active <= 1'b1;
    end else if (active && run_i && tick_i) begin
      if (count == {W{1'b0}}) begin
        active <= 1'b0;
      end else begin
        count <= count - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
  // Rollover: zero reached on a tick
  assign done_o = active && run_i && tick_i && (count == {W{1'b0}});
endmodule // i2m_divider

//--- hw/i2m_port.v
`timescale 1ns/1ps
// What this block does
// - All-zero address byte with write bit zero is the general call
// - General call recognized only while gencall_enable is set
// - After Start, shift eight bits, compare with own address and general call
// - On general call, buffer byte, set buffer_full at bit eight, flag at ninth
// - Ten-bit general call leaves upper_addr_pending clear, data follows
// - Ten-bit header match sets upper_addr_pending; software rewrites address
// - Master active when mode bits select it and port enabled; hardware drives lines
// - start_seen and stop_seen clear on reset or disable; bus free per them
// - Data write during Start is dropped and sets write_collision
// - Event flag on Start, Stop, Repeated Start, ack sent, each byte
// - Master makes all clocks, Start and Stop; Repeated Start keeps bus
// - Transmit eight bits per byte, acknowledge received after each
// - Receive eight bits per byte, master sends acknowledge after each
// - Slave acknowledge after each sent byte stored in ack status
// - Event flag at end of ninth clock of each sent byte
// - Software requests Stop; event raised when Stop has finished
// - Divider reloads from low seven address bits, counts to zero, stops
// - Divider decrements on phase two and phase four, auto-reloaded
// - After an operation the divider stops and SCL holds its level
// - Released SCL pauses divider until sampled high, then reloads
module i2m_port #(
  parameter DIV_W = 7
) (
  // Clock and reset
  input  wire             clk_sys_i,
  input  wire             nrst_i,
  // Configuration
  input  wire             port_enable_i,
  input  wire [3:0]       port_mode_bits_i,
  input  wire             gencall_enable_i,
  input  wire             ten_bit_mode_i,
  input  wire [7:0]       own_address_reg_i,
  input  wire             own_address_wr_i,
  // Commands
  input  wire             start_request_i,
  input  wire             rstart_request_i,
  input  wire             stop_request_i,
  input  wire             recv_request_i,
  input  wire             ack_request_i,
  input  wire             ack_data_i,
  input  wire [7:0]       data_wr_i,
  input  wire             data_wr_en_i,
  input  wire             data_rd_i,
  input  wire             event_clr_i,
  input  wire             write_collision_clr_i,
  // Status
  output reg  [7:0]       data_buffer_o,
  output reg              buffer_full_o,
  output reg              serial_event_flag_o,
  output reg              write_collision_o,
  output reg              ack_status_o,
  output reg              upper_addr_pending_o,
  output reg              start_seen_o,
  output reg              stop_seen_o,
  output reg              gencall_hit_o,
  output wire             bus_free_o,
  output wire             busy_o,
  // Two-wire pins, enable low while driving low
  input  wire             scl_i,
  output wire             scl_o,
  output wire             scl_oe_n_o,
  input  wire             sda_i,
  output wire             sda_o,
  output wire             sda_oe_n_o
);
`include "i2m_map.vh"
  // Master states
  localparam ST_IDLE  = 4'h0;
  localparam ST_STA1  = 4'h1;
  localparam ST_STA2  = 4'h2;
  localparam ST_RS1   = 4'h3;
  localparam ST_RS2   = 4'h4;
  localparam ST_TXL   = 4'h5;
  localparam ST_TXH   = 4'h6;
  localparam ST_RXL   = 4'h7;
  localparam ST_RXH   = 4'h8;
  localparam ST_AKL   = 4'h9;
  localparam ST_AKH   = 4'hA;
  localparam ST_SP1   = 4'hB;
  localparam ST_SP2   = 4'hC;
  localparam ST_SP3   = 4'hD;
  localparam ST_RS0   = 4'hE;

  reg [3:0]  state;
  reg [3:0]  bitcnt;
  reg [7:0]  shreg;
  reg        scl_low;
  reg        sda_low;
  reg        scl_prev;
  reg        sda_prev;
  reg        div_load;
  reg        ack_low;
  // Slave side
  reg [3:0]  sl_bits;
  reg        sl_active;
  reg [7:0]  sl_shift;
  reg        sl_gc;
  wire       tick;
  wire       div_done;
  wire       master_on;
  wire       waiting_high;
  wire       start_det;
  wire       stop_det;
  wire       scl_rise;
  wire       scl_fall;
  wire [7:0] gc_byte;

  // Master mode selection
  assign master_on = port_enable_i && (port_mode_bits_i == `I2M_MODE_MASTER);
  assign bus_free_o = stop_seen_o || (!start_seen_o && !stop_seen_o);
  assign busy_o = (state != ST_IDLE);
  assign gc_byte = `I2M_GENCALL_BYTE;
  // Open-drain drive: only low, enable low while driving
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n_o = !(master_on && scl_low);
  assign sda_oe_n_o = !((master_on && sda_low) || (port_enable_i && ack_low)); // Slave ack too

  // Bus condition detection
  assign start_det = scl_i && scl_prev && sda_prev && !sda_i;
  assign stop_det  = scl_i && scl_prev && !sda_prev && sda_i;
  assign scl_rise  = scl_i && !scl_prev;
  assign scl_fall  = !scl_i && scl_prev;
  // Divider halts while released SCL is still held low elsewhere
  assign waiting_high = !scl_low && !scl_i;

  // Phase enables
  i2m_phase_gen u_phase (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .tick_o    (tick)
  );

  // Baud divider
  i2m_divider #(
    .W (DIV_W)
  ) u_div (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .tick_i    (tick),
    .load_i    (div_load),
    .run_i     (!waiting_high),
    .reload_i  (own_address_reg_i[DIV_W-1:0]),
    .done_o    (div_done)
  );

  // Line history
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_i;
      sda_prev <= sda_i;
    end
  end

  // Start and stop status bits
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_seen_o <= 1'b0;
      stop_seen_o  <= 1'b0;
    end else if (!port_enable_i) begin
      start_seen_o <= 1'b0;
      stop_seen_o  <= 1'b0;
    end else if (start_det) begin
      start_seen_o <= 1'b1;
      stop_seen_o  <= 1'b0;
    end else if (stop_det) begin
      start_seen_o <= 1'b0;
      stop_seen_o  <= 1'b1;
    end
  end

  // Master sequencer, data buffer and status flags
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state                <= ST_IDLE;
      bitcnt               <= 4'h0;
      shreg                <= 8'h00;
      scl_low              <= 1'b0;
      sda_low              <= 1'b0;
      div_load             <= 1'b0;
      data_buffer_o        <= 8'h00;
      buffer_full_o        <= 1'b0;
      serial_event_flag_o  <= 1'b0;
      write_collision_o    <= 1'b0;
      ack_status_o         <= 1'b0;
      upper_addr_pending_o <= 1'b0;
      gencall_hit_o        <= 1'b0;
      sl_bits              <= 4'h0;
      sl_active            <= 1'b0;
      sl_shift             <= 8'h00;
      sl_gc                <= 1'b0;
      ack_low              <= 1'b0;
    end else begin
      div_load <= 1'b0;
      // Software clears, hardware sets below win
      if (event_clr_i) serial_event_flag_o <= 1'b0;
      if (write_collision_clr_i) write_collision_o <= 1'b0;
      if (data_rd_i) buffer_full_o <= 1'b0;
      if (own_address_wr_i) upper_addr_pending_o <= 1'b0;
      if (!master_on) begin
        state   <= ST_IDLE;
        scl_low <= 1'b0;
        sda_low <= 1'b0;
        // Slave address recognition
        if (start_det) begin
          sl_active <= port_enable_i;
          sl_bits   <= 4'h0;
          sl_gc     <= 1'b0;
          ack_low   <= 1'b0;
        end else if (stop_det) begin
          sl_active <= 1'b0;
          ack_low   <= 1'b0;
        end else if (sl_active && scl_rise && sl_bits <= `I2M_BITS_LAST) begin
          sl_shift <= {sl_shift[6:0], sda_i};
          sl_bits  <= sl_bits + 4'h1;
          if (sl_bits == `I2M_BITS_LAST) begin
            if (gencall_enable_i && {sl_shift[6:0], sda_i} == gc_byte) begin
              data_buffer_o <= {sl_shift[6:0], sda_i};
              buffer_full_o <= 1'b1;
              sl_gc         <= 1'b1;
              gencall_hit_o <= 1'b1;
            end else if (ten_bit_mode_i &&
                         sl_shift[6:2] == `I2M_TENBIT_HDR &&
                         sl_shift[1:0] == own_address_reg_i[2:1]) begin
              data_buffer_o        <= {sl_shift[6:0], sda_i};
              buffer_full_o        <= 1'b1;
              upper_addr_pending_o <= 1'b1;
              sl_gc                <= 1'b1;
            end else if (!ten_bit_mode_i &&
                         sl_shift[6:0] == own_address_reg_i[7:1]) begin
              data_buffer_o <= {sl_shift[6:0], sda_i};
              buffer_full_o <= 1'b1;
              sl_gc         <= 1'b1;
              gencall_hit_o <= 1'b0;
            end else begin
              sl_active <= 1'b0;
            end
          end
        end else if (sl_active && scl_fall && sl_bits == `I2M_BIT_ACK && sl_gc) begin
          ack_low <= 1'b1; // Drive acknowledge for the ninth bit
          sl_bits <= sl_bits + 4'h1;
        end else if (sl_active && scl_fall && sl_bits > `I2M_BIT_ACK) begin
          ack_low             <= 1'b0;
          serial_event_flag_o <= 1'b1;
          sl_active           <= 1'b0;
        end
      end else begin
        ack_low <= 1'b0;
        // Buffer write: only accepted when idle
        if (data_wr_en_i) begin
          if (state != ST_IDLE) begin
            write_collision_o <= 1'b1;
          end else begin
            data_buffer_o <= data_wr_i;
            shreg         <= data_wr_i;
            buffer_full_o <= 1'b1;
            bitcnt        <= 4'h0;
            scl_low       <= 1'b1;
            state         <= ST_TXL;
            div_load      <= 1'b1;
          end
        end
        case (state)
          ST_IDLE: begin
            if (data_wr_en_i) begin
              state <= ST_TXL;
            end else if (start_request_i && scl_i && sda_i) begin
              state    <= ST_STA1;
              div_load <= 1'b1;
            end else if (rstart_request_i) begin
              scl_low  <= 1'b1;
              sda_low  <= 1'b0;
              state    <= ST_RS0;
              div_load <= 1'b1;
            end else if (stop_request_i) begin
              scl_low  <= 1'b1;
              sda_low  <= 1'b1;
              state    <= ST_SP1;
              div_load <= 1'b1;
            end else if (recv_request_i) begin
              bitcnt   <= 4'h0;
              scl_low  <= 1'b1;
              sda_low  <= 1'b0;
              state    <= ST_RXL;
              div_load <= 1'b1;
            end else if (ack_request_i) begin
              scl_low  <= 1'b1;
              sda_low  <= !ack_data_i;
              state    <= ST_AKL;
              div_load <= 1'b1;
            end
          end
          ST_STA1: if (div_done) begin
            sda_low  <= 1'b1;
            state    <= ST_STA2;
            div_load <= 1'b1;
          end
          ST_STA2: if (div_done) begin
            serial_event_flag_o <= 1'b1;
            state               <= ST_IDLE;
          end
          ST_RS0: if (div_done) begin
            scl_low  <= 1'b0;
            state    <= ST_RS1;
            div_load <= 1'b1;
          end
          ST_RS1: if (waiting_high) begin
            div_load <= 1'b1;
          end else if (div_done) begin
            sda_low  <= 1'b1;
            state    <= ST_RS2;
            div_load <= 1'b1;
          end
          ST_RS2: if (div_done) begin
            serial_event_flag_o <= 1'b1;
            state               <= ST_IDLE;
          end
          // Low half: set SDA, then release SCL
          ST_TXL: if (div_done) begin
            scl_low  <= 1'b0;
            state    <= ST_TXH;
            div_load <= 1'b1;
          end
          ST_TXH: if (waiting_high) begin
            div_load <= 1'b1;
          end else if (div_done) begin
            scl_low  <= 1'b1;
            bitcnt   <= bitcnt + 4'h1;
            div_load <= 1'b1;
            if (bitcnt == `I2M_BIT_ACK) begin
              ack_status_o        <= sda_i;
              serial_event_flag_o <= 1'b1;
              sda_low             <= 1'b0;
              div_load            <= 1'b0;
              state               <= ST_IDLE;
            end else begin
              state <= ST_TXL;
              if (bitcnt == `I2M_BITS_LAST) begin
                buffer_full_o <= 1'b0;
                sda_low       <= 1'b0;
              end else begin
                sda_low <= !shreg[6];
                shreg   <= {shreg[6:0], 1'b0};
              end
            end
          end
          ST_RXL: if (div_done) begin
            scl_low  <= 1'b0;
            state    <= ST_RXH;
            div_load <= 1'b1;
          end
          ST_RXH: if (waiting_high) begin
            div_load <= 1'b1;
          end else if (div_done) begin
            scl_low <= 1'b1;
            shreg   <= {shreg[6:0], sda_i};
            bitcnt  <= bitcnt + 4'h1;
            if (bitcnt == `I2M_BITS_LAST) begin
              data_buffer_o       <= {shreg[6:0], sda_i};
              buffer_full_o       <= 1'b1;
              serial_event_flag_o <= 1'b1;
              state               <= ST_IDLE;
            end else begin
              div_load <= 1'b1;
              state    <= ST_RXL;
            end
          end
          ST_AKL: if (div_done) begin
            scl_low  <= 1'b0;
            state    <= ST_AKH;
            div_load <= 1'b1;
          end
          ST_AKH: if (waiting_high) begin
            div_load <= 1'b1;
          end else if (div_done) begin
            scl_low             <= 1'b1;
            serial_event_flag_o <= 1'b1;
            state               <= ST_IDLE;
          end
          ST_SP1: if (div_done) begin
            scl_low  <= 1'b0;
            state    <= ST_SP2;
            div_load <= 1'b1;
          end
          ST_SP2: if (waiting_high) begin
            div_load <= 1'b1;
          end else if (div_done) begin
            sda_low  <= 1'b0;
            state    <= ST_SP3;
            div_load <= 1'b1;
          end
          ST_SP3: if (div_done) begin
            serial_event_flag_o <= 1'b1;
            state               <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
        // Before SCL is released, the first bit goes out with the write
        if (data_wr_en_i && state == ST_IDLE) begin
          sda_low <= !data_wr_i[7];
        end
      end
    end
  end
endmodule // i2m_port

//--- dv/i2m_port_assertions.sv
`timescale 1ns/1ps
`include "i2m_map.vh"
// Port-level checks of the master engine and the slave address logic
module i2m_port_assertions (
  // Clock and reset
  input wire       clk_sys_i,
  input wire       nrst_i,
  // Configuration and commands
  input wire       port_enable_i,
  input wire [3:0] port_mode_bits_i,
  input wire       gencall_enable_i,
  input wire       start_request_i,
  input wire       rstart_request_i,
  input wire       stop_request_i,
  input wire       recv_request_i,
  input wire       ack_request_i,
  input wire       data_wr_en_i,
  input wire       event_clr_i,
  // Status and pins
  input wire [7:0] data_buffer_o,
  input wire       serial_event_flag_o,
  input wire       write_collision_o,
  input wire       start_seen_o,
  input wire       stop_seen_o,
  input wire       gencall_hit_o,
  input wire       bus_free_o,
  input wire       busy_o,
  input wire       scl_i,
  input wire       scl_oe_n_o,
  input wire       sda_oe_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // Master selected, and no request of any kind this cycle
  wire master = port_enable_i && port_mode_bits_i == `I2M_MODE_MASTER;
  wire no_req = !(start_request_i || rstart_request_i || stop_request_i ||
                  recv_request_i || ack_request_i || data_wr_en_i);

  a_lines_off: assert property (!port_enable_i ##1 !port_enable_i |->
    scl_oe_n_o && sda_oe_n_o)
    else $error("lines pulled while port off");
  a_off_clears: assert property (!port_enable_i |=> !start_seen_o && !stop_seen_o)
    else $error("bus state bits not cleared");
  a_bus_free: assert property (bus_free_o == (stop_seen_o || !start_seen_o))
    else $error("bus free level wrong");
  a_write_collision_set: assert property (data_wr_en_i && busy_o |=> write_collision_o)
    else $error("collision not flagged");
  a_flag_holds: assert property (serial_event_flag_o && !event_clr_i |=>
    serial_event_flag_o)
    else $error("event flag dropped");
  a_scl_low_min: assert property (master && $fell(scl_oe_n_o) |=> !scl_oe_n_o [*3])
    else $error("clock low phase too short");
  a_scl_high_min: assert property (master && $rose(scl_i) && scl_oe_n_o |->
    scl_oe_n_o [*4])
    else $error("clock high phase too short");
  a_idle_still: assert property (master && !busy_o && no_req |=> $stable(scl_oe_n_o))
    else $error("clock moved while idle");
  a_gencall_gate: assert property ($rose(gencall_hit_o) |-> gencall_enable_i ##[0:2]
    data_buffer_o == `I2M_GENCALL_BYTE)
    else $error("general call taken wrongly");
  a_stop_event: assert property (master && $rose(stop_seen_o) |->
    ##[0:60] serial_event_flag_o)
    else $error("no event after stop");

  // Main scenarios reached
  c_start: cover property (master && $rose(start_seen_o));
  c_write_collision: cover property ($rose(write_collision_o));
  c_gencall: cover property ($rose(gencall_hit_o));
  c_stop: cover property (master && $rose(stop_seen_o));
endmodule // i2m_port_assertions

bind i2m_port i2m_port_assertions i_chk (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .port_enable_i(port_enable_i),
  .port_mode_bits_i(port_mode_bits_i), .gencall_enable_i(gencall_enable_i),
  .start_request_i(start_request_i), .rstart_request_i(rstart_request_i),
  .stop_request_i(stop_request_i), .recv_request_i(recv_request_i),
  .ack_request_i(ack_request_i), .data_wr_en_i(data_wr_en_i), .event_clr_i(event_clr_i),
  .data_buffer_o(data_buffer_o), .serial_event_flag_o(serial_event_flag_o),
  .write_collision_o(write_collision_o), .start_seen_o(start_seen_o),
  .stop_seen_o(stop_seen_o), .gencall_hit_o(gencall_hit_o), .bus_free_o(bus_free_o),
  .busy_o(busy_o), .scl_i(scl_i), .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o)
);

//--- dv/i2m_slave_model.sv
`timescale 1ns/1ps
// Addressed slave: acks its address, stretches each low phase, returns one byte
module i2m_slave_model #(
  parameter logic [6:0] ADDR    = 7'h50,
  parameter int         STRETCH = 10
) (
  // Clock and resolved lines
  input  wire logic       clk_sys_i,
  input  wire logic       en_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] tx_byte_i,
  // Open-drain pulls, low pulls the line low
  output logic            scl_hold_n_o,
  output logic            sda_drv_n_o,
  output logic [7:0]      rx_byte_o,
  output logic            ack_seen_o
);
  logic       scl_q, sda_q, addr_ph, sel, rd;
  logic [3:0] bitn;
  logic [7:0] sh;
  int         hold;
  initial begin
    {scl_q, sda_q, scl_hold_n_o, sda_drv_n_o, ack_seen_o} = 5'h1F;
    {addr_ph, sel, rd, bitn, sh, rx_byte_o, hold} = '0;
  end
  // Bus watcher, edges found against the previous sample
  always @(posedge clk_sys_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (hold != 0) begin
      hold <= hold - 1;
      if (hold == 1) scl_hold_n_o <= 1'b1;
    end
    if (!en_i) begin
      {scl_hold_n_o, sda_drv_n_o, sel} <= 3'h6;
    end else if (scl_q && scl_i && sda_q != sda_i) begin
      // Start or stop condition
      bitn <= 4'h0;
      addr_ph <= !sda_i;
      sel <= 1'b0;
      sda_drv_n_o <= 1'b1;
    end else if (!scl_q && scl_i) begin
      if (bitn < 4'h8) sh <= {sh[6:0], sda_i};
      if (bitn == 4'h8) ack_seen_o <= sda_i;
      bitn <= bitn + 4'h1;
    end else if (scl_q && !scl_i) begin
      // Hold the clock low longer than the master wants
      hold <= STRETCH;
      scl_hold_n_o <= 1'b0;
      if (bitn == 4'h8) begin
        rx_byte_o <= sh;
        if (addr_ph) begin
          sel <= sh[7:1] == ADDR;
          rd <= sh[0];
          sda_drv_n_o <= sh[7:1] != ADDR;
        end else begin
          sda_drv_n_o <= !(sel && !rd);
        end
      end else if (bitn == 4'h9) begin
        bitn <= 4'h0;
        addr_ph <= 1'b0;
        sda_drv_n_o <= (sel && rd && (addr_ph || !ack_seen_o)) ? tx_byte_i[7] : 1'b1;
      end else if (sel && rd && !addr_ph && bitn != 4'h0) begin
        sda_drv_n_o <= tx_byte_i[3'd7 - bitn[2:0]];
      end
    end
  end
endmodule // i2m_slave_model

//--- dv/i2m_port_tb_top.sv
`timescale 1ns/1ps
`include "i2m_map.vh"
// Self-checking bench for the two-wire port
module i2m_port_tb_top;
  logic       clk_sys_i, nrst_i, en, ten, gce, wr_en, ackd, tb_scl_n, tb_sda_n, m_en;
  logic [3:0] mode;
  logic [7:0] own, wdat, b0;
  logic [8:0] pv;
  logic [2:0] pre;
  logic       a;
  wire  [7:0] dbuf, rxb;
  wire        bf, flag, write_collision, acks, ua, ss, ps, gch, bfree, busy, scl_oe_n, sda_oe_n;
  wire        m_scl_n, m_sda_n, mack;
  int         miscompares, checks_done;
  // Open-drain lines with pull-ups
  wire scl = scl_oe_n & m_scl_n & tb_scl_n;
  wire sda = sda_oe_n & m_sda_n & tb_sda_n;

  i2m_port i_i2m_port (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .port_enable_i(en), .port_mode_bits_i(mode),
    .gencall_enable_i(gce), .ten_bit_mode_i(ten), .own_address_reg_i(own),
    .own_address_wr_i(pv[8]), .start_request_i(pv[0]), .rstart_request_i(pv[1]),
    .stop_request_i(pv[2]), .recv_request_i(pv[3]), .ack_request_i(pv[4]),
    .ack_data_i(ackd), .data_wr_i(wdat), .data_wr_en_i(wr_en), .data_rd_i(pv[7]),
    .event_clr_i(pv[5]), .write_collision_clr_i(pv[6]), .data_buffer_o(dbuf), .buffer_full_o(bf),
    .serial_event_flag_o(flag), .write_collision_o(write_collision), .ack_status_o(acks),
    .upper_addr_pending_o(ua), .start_seen_o(ss), .stop_seen_o(ps), .gencall_hit_o(gch),
    .bus_free_o(bfree), .busy_o(busy), .scl_i(scl), .scl_o(), .scl_oe_n_o(scl_oe_n),
    .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n));
  i2m_slave_model i_i2m_slave_model (
    .clk_sys_i(clk_sys_i), .en_i(m_en), .scl_i(scl), .sda_i(sda), .tx_byte_i(8'hC5),
    .scl_hold_n_o(m_scl_n), .sda_drv_n_o(m_sda_n), .rx_byte_o(rxb), .ack_seen_o(mack));

  // 200 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      miscompares++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One-cycle strobe on a command or clear input
  task automatic pulse(input int i);
    @(negedge clk_sys_i) pv[i] = 1'b1;
    @(negedge clk_sys_i) pv[i] = 1'b0;
  endtask
  task automatic put(input logic [7:0] b);
    @(negedge clk_sys_i) begin wdat = b; wr_en = 1'b1; end
    @(negedge clk_sys_i) wr_en = 1'b0;
  endtask
  task automatic wait_flag(input string what);
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 3000) begin @(negedge clk_sys_i); n++; end
    chk(flag === 1'b1, what);
    pulse(5);
  endtask
  // Bench as bus master for the slave path
  task automatic bb(input logic s, input logic d);
    @(negedge clk_sys_i) begin tb_scl_n = s; tb_sda_n = d; end
    repeat (10) @(negedge clk_sys_i);
  endtask
  task automatic frame(input logic [7:0] b);
    bb(1, 1); bb(1, 0); bb(0, 0);
    for (int i = 7; i >= 0; i--) begin bb(0, b[i]); bb(1, b[i]); bb(0, b[i]); end
    bb(0, 1); bb(1, 1);
    a = sda;
    pre = {flag, bf, gch};
    bb(0, 1); bb(0, 0); bb(1, 0); bb(1, 1);
  endtask

  initial begin
    {nrst_i, ten, gce, wr_en, ackd, wdat, pv, m_en} = '0;
    {en, tb_scl_n, tb_sda_n, m_en} = 4'hF;
    mode = `I2M_MODE_MASTER;
    own = 8'h02;
    repeat (10) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    @(negedge clk_sys_i);
    chk(ss === 0 && ps === 0 && flag === 0 && bfree === 1 && scl_oe_n === 1 && sda_oe_n === 1,
        "reset state");
    b0 = dbuf;
    pulse(0);
    put(8'hFF);
    wait_flag("start event");
    chk(write_collision === 1'b1 && dbuf === b0, "write during start");
    chk(ss === 1'b1 && sda === 1'b0 && scl === 1'b1, "start");
    pulse(6);
    chk(write_collision === 1'b0, "collision cleared");
    put(8'hA0);
    wait_flag("address sent");
    chk(acks === 1'b0 && rxb === 8'hA0, "address byte");
    put(8'h3C);
    wait_flag("data sent");
    chk(acks === 1'b0 && rxb === 8'h3C, "data byte");
    $display("test write done");
    pulse(1);
    wait_flag("repeated start");
    put(8'hA1);
    wait_flag("read address");
    pulse(3);
    wait_flag("byte received");
    chk(dbuf === 8'hC5 && bf === 1'b1, "received byte");
    pulse(7);
    chk(bf === 1'b0, "buffer read");
    pulse(4);
    wait_flag("ack sent");
    chk(mack === 1'b0, "master ack bit");
    pulse(2);
    wait_flag("stop done");
    chk(ps === 1 && bfree === 1 && scl === 1 && sda === 1, "stop");
    $display("test read done");
    pulse(0);
    wait_flag("start again");
    put(8'hA4);
    wait_flag("unmatched address");
    chk(acks === 1'b1, "no acknowledge");
    pulse(2);
    wait_flag("stop again");
    @(negedge clk_sys_i) en = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk(ss === 0 && ps === 0 && scl_oe_n === 1 && sda_oe_n === 1, "port off");
    $display("test nack done");
    {mode, m_en, ten, gce, en} = 8'h07;
    frame(8'h00);
    chk(a === 1'b0 && pre === 3'b011, "general call byte");
    chk(flag === 1'b1 && dbuf === 8'h00 && ua === 1'b0, "general call");
    pulse(5);
    pulse(7);
    gce = 1'b0;
    frame(8'h00);
    chk(a === 1'b1 && flag === 1'b0, "general call off");
    frame(8'hF2);
    chk(a === 1'b0 && ua === 1'b1, "ten-bit header");
    pulse(8);
    chk(ua === 1'b0, "address rewritten");
    $display("test slave done");
    conclude();
  end

  // Watchdog for a hung handshake
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    miscompares++;
    $display("wrong value at %0t ns: run timed out", $time);
    conclude();
  end
endmodule // i2m_port_tb_top
